/* hw/dif_cfg.svh */
// Constants for the digital input function logic: offsets, field positions, resets, widths.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a 20 MHz core clock.
// Functional notes
// (RULE1) Eight counters each count one per inactive-to-active change of their input.
// (RULE2) A counter is held at zero while its clear input is active.
// (RULE3) Four derating requests, each using its own configured parameter set.
// (RULE4) Mixer control input: 1 selects manual, 0 selects automatic mode.
// (RULE5) Gas-type input picks the mixer setpoint set applied when the engine starts.
// (RULE6) Operation inhibit blocks automatic starts; test and remote starts still pass.
// (RULE7) In automatic mode load inhibit opens generator breaker, closes mains breaker.
// (RULE8) In automatic modes mains closure inhibit keeps the mains breaker open.
// (RULE9) If remote-start enable is configured, remote start is ignored while it is inactive.
// (RULE10) Load-threshold management is suspended while its enable input is inactive.
// (RULE11) Auxiliary fourth-current protection is suppressed while its disable input is active.
// (RULE12) Analogue disable suppresses only thresholds whose third parameter has bit 13 set.
// (RULE13) Serial enable inactive rejects Modbus writes to holding registers 101 and 102.
// (RULE14) Inputs are synchronised and edges taken on the synchronised value.
// (RULE15) Counters have a fixed width, wrap on overflow; clear beats increment.
`ifndef DIF_CFG_SVH
`define DIF_CFG_SVH

// ==========================================================================
// Register byte offsets.
`define DIF_OFS_CNT0 8'h00
`define DIF_OFS_STATUS 8'h20
`define DIF_OFS_MASK 8'h24
`define DIF_OFS_CTRL 8'h28
`define DIF_OFS_INPUTS 8'h2c
`define DIF_OFS_DERATE0 8'h30
`define DIF_OFS_MIXSP0 8'h40
`define DIF_OFS_MIXSP1 8'h44

// ==========================================================================
// Field positions and widths.
`define DIF_CNT_W 16
`define DIF_NUM_CNT 8
`define DIF_NUM_DERATE 4
`define DIF_NUM_ANA 4
`define DIF_ST_W 10
`define DIF_ST_MB_REJ 8
`define DIF_ST_START_BLK 9
`define DIF_CTRL_RSTART_CFG 0
`define DIF_ANA_SUPPR_BIT 13
`define DIF_MB_REG_A 16'h0065
`define DIF_MB_REG_B 16'h0066

// ==========================================================================
// Reset values.
`define DIF_RST_MASK 10'h000
`define DIF_RST_CTRL 1'h0
`define DIF_RST_PARAM 16'h0000

`endif

/* hw/dif_logic.sv */
// Digital input function logic: counters, derating, mixer, breaker and start gating.
// Assumes field inputs are asynchronous levels and an Avalon-MM master on the core clock.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "dif_cfg.svh"

module dif_logic (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Avalon-MM slave.
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  // Field contacts.
  input wire dif_pkg::dif_field_s i_field,
  // Controller operating state and requests.
  input wire logic i_auto_mode,
  input wire logic i_auto_start_req,
  input wire logic i_test_start_req,
  input wire logic i_remote_start_req,
  input wire logic i_engine_starting,
  input wire logic i_gen_brk_close_req,
  input wire logic i_mains_brk_close_req,
  input wire logic i_mains_brk_used,
  input wire dif_pkg::dif_ana_s [3:0] i_ana,
  input wire logic i_mb_wr_valid,
  input wire logic [15:0] i_mb_wr_reg,
  // Commands to engine, breakers and protections.
  output logic o_start_cmd,
  output logic o_gen_brk_close,
  output logic o_mains_brk_close,
  output logic o_derate_active,
  output logic [1:0] o_derate_sel,
  output logic [15:0] o_derate_param,
  output logic o_mixer_manual,
  output logic [15:0] o_mixer_sp,
  output logic o_load_thr_en,
  output logic o_aux_prot_en,
  output logic [3:0] o_ana_trip,
  output logic o_mb_wr_accept,
  output logic o_mb_wr_reject
);

  // ==========================================================================
  // Helpers.
  function automatic logic [7:0] dif_rise(input logic [7:0] cur, input logic [7:0] prev);
    dif_rise = cur & ~prev;
  endfunction : dif_rise

  function automatic logic [15:0] dif_merge16(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
    dif_merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : dif_merge16

  localparam int FW = $bits(dif_pkg::dif_field_s);

  // ==========================================================================
  // Input synchronisers; stage one feeds stage two only.
  logic [FW-1:0] sync1_r;
  logic [FW-1:0] sync2_r;
  logic [7:0] cnt_prev_r;
  dif_pkg::dif_field_s fs;
  logic [7:0] cnt_rise;

  // Two flops per contact, then a delayed copy of the counter inputs for edges.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      cnt_prev_r <= 8'h00;
    end else begin
      sync1_r <= i_field; // [RULE14]
      sync2_r <= sync1_r; // [RULE14]
      cnt_prev_r <= fs.cnt_in;
    end
  end

  assign fs = dif_pkg::dif_field_s'(sync2_r);
  assign cnt_rise = dif_rise(fs.cnt_in, cnt_prev_r); // [RULE1] [RULE14]

  // ==========================================================================
  // Pulse counters.
  logic [`DIF_CNT_W-1:0] cnt_r [`DIF_NUM_CNT];

  // A held clear keeps the count at zero and beats a coincident edge.
  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < `DIF_NUM_CNT; i++) begin
      if (!i_resetn) begin
        cnt_r[i] <= '0;
      end else if (fs.cnt_clr[i]) begin
        cnt_r[i] <= '0; // [RULE2] [RULE15]
      end else if (cnt_rise[i]) begin
        cnt_r[i] <= cnt_r[i] + `DIF_CNT_W'(1); // [RULE1] [RULE15]
      end
    end
  end

  // ==========================================================================
  // Register file and Avalon-MM slave.
  dif_pkg::dif_bus_e bus_r;
  logic [`DIF_ST_W-1:0] status_r;
  logic [`DIF_ST_W-1:0] mask_r;
  logic ctrl_rstart_cfg_r;
  logic [15:0] derate_par_r [`DIF_NUM_DERATE];
  logic [15:0] mixsp_r [2];
  logic [31:0] rdata_nxt;
  logic req;
  logic wr_go;
  logic rd_done;
  logic [`DIF_ST_W-1:0] st_evt;

  assign req = i_avs_read | i_avs_write;
  // One wait cycle per access keeps read data registered at the completing edge.
  assign o_avs_waitrequest = req & (bus_r == dif_pkg::BUS_IDLE);
  assign wr_go = i_avs_write & (bus_r == dif_pkg::BUS_ACK);
  assign rd_done = i_avs_read & (bus_r == dif_pkg::BUS_ACK);

  // Bus state: idle, then one acknowledge cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      bus_r <= dif_pkg::BUS_IDLE;
    end else begin
      case (bus_r)
        dif_pkg::BUS_IDLE: bus_r <= req ? dif_pkg::BUS_ACK : dif_pkg::BUS_IDLE;
        dif_pkg::BUS_ACK: bus_r <= dif_pkg::BUS_IDLE;
        default: bus_r <= dif_pkg::BUS_IDLE;
      endcase
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (i_avs_address < `DIF_OFS_STATUS) begin
      rdata_nxt = {16'h0000, cnt_r[i_avs_address[4:2]]};
    end else if (i_avs_address >= `DIF_OFS_DERATE0 && i_avs_address < `DIF_OFS_MIXSP0) begin
      rdata_nxt = {16'h0000, derate_par_r[i_avs_address[3:2]]};
    end else begin
      case (i_avs_address)
        `DIF_OFS_STATUS: rdata_nxt = {22'h000000, status_r};
        `DIF_OFS_MASK: rdata_nxt = {22'h000000, mask_r};
        `DIF_OFS_CTRL: rdata_nxt = {31'h00000000, ctrl_rstart_cfg_r};
        `DIF_OFS_INPUTS: rdata_nxt = {{(32 - FW){1'b0}}, sync2_r};
        `DIF_OFS_MIXSP0: rdata_nxt = {16'h0000, mixsp_r[0]};
        `DIF_OFS_MIXSP1: rdata_nxt = {16'h0000, mixsp_r[1]};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data captured while waitrequest is high, so it stands at the completing edge.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && bus_r == dif_pkg::BUS_IDLE) begin
      o_avs_readdata <= rdata_nxt;
    end
  end

  // Writable configuration registers.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      mask_r <= `DIF_RST_MASK;
      ctrl_rstart_cfg_r <= `DIF_RST_CTRL;
      for (int i = 0; i < `DIF_NUM_DERATE; i++) derate_par_r[i] <= `DIF_RST_PARAM;
      mixsp_r[0] <= `DIF_RST_PARAM;
      mixsp_r[1] <= `DIF_RST_PARAM;
    end else if (wr_go) begin
      if (i_avs_address >= `DIF_OFS_DERATE0 && i_avs_address < `DIF_OFS_MIXSP0) begin
        derate_par_r[i_avs_address[3:2]] <=
          dif_merge16(derate_par_r[i_avs_address[3:2]], i_avs_writedata, i_avs_byteenable);
      end
      case (i_avs_address)
        `DIF_OFS_MASK: mask_r <= {i_avs_byteenable[1] ? i_avs_writedata[9:8] : mask_r[9:8],
                                  i_avs_byteenable[0] ? i_avs_writedata[7:0] : mask_r[7:0]};
        `DIF_OFS_CTRL: if (i_avs_byteenable[0]) ctrl_rstart_cfg_r <= i_avs_writedata[0];
        `DIF_OFS_MIXSP0: mixsp_r[0] <= dif_merge16(mixsp_r[0], i_avs_writedata, i_avs_byteenable);
        `DIF_OFS_MIXSP1: mixsp_r[1] <= dif_merge16(mixsp_r[1], i_avs_writedata, i_avs_byteenable);
        default: ;
      endcase
    end
  end

  // Sticky status: a completed read clears only the bits it returned, so an event that
  // lands while the read waits is kept; a same-cycle event still sets.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~((rd_done && i_avs_address == `DIF_OFS_STATUS) ?
                  o_avs_readdata[`DIF_ST_W-1:0] : `DIF_ST_W'(0))) | st_evt;
    end
  end

  assign o_irq = |(status_r & mask_r);

  // ==========================================================================
  // Start gating.
  logic rstart_ok;
  logic auto_blocked;
  logic auto_blocked_r;

  // Without a configured enable input, remote start passes unconditionally.
  assign rstart_ok = i_remote_start_req & (~ctrl_rstart_cfg_r | fs.rstart_en); // [RULE9]
  assign auto_blocked = i_auto_start_req & fs.op_inhibit;

  // Automatic starts obey the inhibit; test and remote starts bypass it.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_start_cmd <= 1'b0;
      auto_blocked_r <= 1'b0;
    end else begin
      o_start_cmd <= (i_auto_start_req & ~fs.op_inhibit) | i_test_start_req | rstart_ok; // [RULE6]
      auto_blocked_r <= auto_blocked;
    end
  end

  // ==========================================================================
  // Breaker commands.
  logic load_inh_auto;
  logic mains_inh_auto;

  assign load_inh_auto = i_auto_mode & fs.load_inhibit;
  assign mains_inh_auto = i_auto_mode & fs.mains_inhibit;

  // Closure inhibit wins over the load inhibit's request to close the mains breaker.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_gen_brk_close <= 1'b0;
      o_mains_brk_close <= 1'b0;
    end else begin
      o_gen_brk_close <= i_gen_brk_close_req & ~load_inh_auto; // [RULE7]
      o_mains_brk_close <= (i_mains_brk_close_req | (load_inh_auto & i_mains_brk_used)) // [RULE7]
                           & ~mains_inh_auto; // [RULE8]
    end
  end

  // ==========================================================================
  // Derating: the lowest-numbered active request supplies its own parameter.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_derate_active <= 1'b0;
      o_derate_sel <= 2'h0;
      o_derate_param <= 16'h0000;
    end else begin
      o_derate_active <= |fs.derate_req; // [RULE3]
      o_derate_sel <= 2'h0;
      o_derate_param <= 16'h0000;
      for (int i = `DIF_NUM_DERATE - 1; i >= 0; i--) begin
        if (fs.derate_req[i]) begin
          o_derate_sel <= 2'(i); // [RULE3]
          o_derate_param <= derate_par_r[i]; // [RULE3]
        end
      end
    end
  end

  // ==========================================================================
  // Mixer mode follows its input each cycle; setpoint set latched at engine start.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_mixer_manual <= 1'b0;
      o_mixer_sp <= 16'h0000;
    end else begin
      o_mixer_manual <= fs.mixer_man; // [RULE4]
      if (i_engine_starting) begin
        o_mixer_sp <= fs.gas_sel ? mixsp_r[1] : mixsp_r[0]; // [RULE5]
      end
    end
  end

  // ==========================================================================
  // Protection gating.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_load_thr_en <= 1'b0;
      o_aux_prot_en <= 1'b0;
      o_ana_trip <= 4'h0;
    end else begin
      o_load_thr_en <= fs.load_thr_en; // [RULE10]
      o_aux_prot_en <= ~fs.aux_dis; // [RULE11]
      for (int i = 0; i < `DIF_NUM_ANA; i++) begin
        o_ana_trip[i] <= i_ana[i].trip &
                         ~(fs.ana_dis & i_ana[i].cfg3[`DIF_ANA_SUPPR_BIT]); // [RULE12]
      end
    end
  end

  // ==========================================================================
  // Serial command acceptance.
  logic mb_guarded;
  logic mb_rej;

  assign mb_guarded = (i_mb_wr_reg == `DIF_MB_REG_A) || (i_mb_wr_reg == `DIF_MB_REG_B);
  assign mb_rej = i_mb_wr_valid & mb_guarded & ~fs.serial_en; // [RULE13]

  // One-cycle verdict per offered write.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_mb_wr_accept <= 1'b0;
      o_mb_wr_reject <= 1'b0;
    end else begin
      o_mb_wr_accept <= i_mb_wr_valid & ~mb_rej;
      o_mb_wr_reject <= mb_rej; // [RULE13]
    end
  end

  assign st_evt = {auto_blocked & ~auto_blocked_r, mb_rej, cnt_rise & ~fs.cnt_clr};

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  cnt_step_a: assert property (cnt_rise[0] && !fs.cnt_clr[0] |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001) else $error("Counter did not step."); // [RULE1]
  cnt_hold_a: assert property (fs.cnt_in[0] && cnt_prev_r[0] && !fs.cnt_clr[0] |=> $stable(cnt_r[0])) else $error("Counter moved on a held input."); // [RULE1]
  cnt_clear_a: assert property (fs.cnt_clr[3] |=> cnt_r[3] == 16'h0000) else $error("Counter not cleared."); // [RULE2] [RULE15]
  sync_lat_a: assert property ($rose(i_field.cnt_in[2]) ##2 !fs.cnt_clr[2] |=> cnt_r[2] == $past(cnt_r[2]) + 16'h0001) else $error("Synchronised edge not counted."); // [RULE14]
  derate_sel_a: assert property (fs.derate_req == 4'h4 |=> o_derate_active && o_derate_sel == 2'h2 && o_derate_param == $past(derate_par_r[2])) else $error("Wrong derating set."); // [RULE3]
  mixer_mode_a: assert property (1'b1 |=> o_mixer_manual == $past(fs.mixer_man)) else $error("Mixer mode wrong."); // [RULE4]
  gas_set_a: assert property (i_engine_starting && fs.gas_sel |=> o_mixer_sp == $past(mixsp_r[1])) else $error("Gas set not applied."); // [RULE5]
  start_inh_a: assert property (fs.op_inhibit && !i_test_start_req && !rstart_ok |=> !o_start_cmd) else $error("Inhibited start issued."); // [RULE6]
  test_start_a: assert property (i_test_start_req |=> o_start_cmd) else $error("Test start blocked."); // [RULE6]
  load_inh_a: assert property (load_inh_auto |=> !o_gen_brk_close) else $error("Generator breaker closed."); // [RULE7]
  mains_inh_a: assert property (mains_inh_auto |=> !o_mains_brk_close) else $error("Mains breaker closed."); // [RULE8]
  rstart_gate_a: assert property (ctrl_rstart_cfg_r && !fs.rstart_en && !i_auto_start_req && !i_test_start_req |=> !o_start_cmd) else $error("Remote start not gated."); // [RULE9]
  load_thr_a: assert property (!fs.load_thr_en |=> !o_load_thr_en) else $error("Thresholds active."); // [RULE10]
  aux_prot_a: assert property (fs.aux_dis |=> !o_aux_prot_en) else $error("Aux protection active."); // [RULE11]
  ana_supp_a: assert property (fs.ana_dis && i_ana[1].cfg3[13] |=> !o_ana_trip[1]) else $error("Analogue trip not suppressed."); // [RULE12]
  ana_keep_a: assert property (i_ana[1].trip && !i_ana[1].cfg3[13] |=> o_ana_trip[1]) else $error("Analogue trip lost."); // [RULE12]
  mb_reject_a: assert property (i_mb_wr_valid && i_mb_wr_reg == 16'h0065 && !fs.serial_en |=> o_mb_wr_reject && !o_mb_wr_accept) else $error("Serial command accepted."); // [RULE13]
  bus_ack_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("Bus answer late.");

  cnt_wrap_c: cover property (cnt_r[0] == 16'hffff ##1 cnt_r[0] == 16'h0000);
  derate_c: cover property (o_derate_active && o_derate_sel == 2'h3);
  mb_rej_c: cover property (o_mb_wr_reject);
  irq_c: cover property (o_irq);

endmodule : dif_logic

/* hw/dif_pkg.sv */
// Types shared by the digital input function logic.
// Assumes the constants header is compiled first.
`include "dif_cfg.svh"

package dif_pkg;

  // ========================================================================
  // Field contacts, all active high after the pins.
  typedef struct packed {
    logic [7:0] cnt_in;
    logic [7:0] cnt_clr;
    logic [3:0] derate_req;
    logic mixer_man;
    logic gas_sel;
    logic op_inhibit;
    logic load_inhibit;
    logic mains_inhibit;
    logic rstart_en;
    logic load_thr_en;
    logic aux_dis;
    logic ana_dis;
    logic serial_en;
  } dif_field_s;

  // One analogue threshold: its raw trip and its third configuration word.
  typedef struct packed {
    logic trip;
    logic [15:0] cfg3;
  } dif_ana_s;

  // Bus slave state.
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } dif_bus_e;

endpackage : dif_pkg

/* tb/dif_field_model.sv */
// Behavioural model of the field contacts that feed the digital input function logic.
// Assumes the bench gives contact levels and one-cycle pulse commands on the core clock.
`timescale 1ns/1ns

module dif_field_model (
  // Clock.
  input wire logic i_core_clk,
  // Commands from the bench.
  input wire dif_pkg::dif_field_s i_lvl,
  input wire logic [7:0] i_pulse,
  // Contacts towards the block.
  output dif_pkg::dif_field_s o_field
);
  // ========================================================================
  // Contact state.
  logic [7:0] hold_r;

  // Contacts start open so the block never sees an unknown level.
  initial begin
    o_field = '0;
    hold_r = 8'h00;
  end

  // A counter contact closes for two cycles per command, then opens again.
  always @(posedge i_core_clk) begin
    o_field <= i_lvl | dif_pkg::dif_field_s'({i_pulse | hold_r, 22'h0});
    hold_r <= i_pulse;
  end
endmodule : dif_field_model

/* tb/dif_logic_bench.sv */
// Self-checking bench for the digital input function logic.
// Assumes the design files are compiled first; the field model drives the contacts.
`timescale 1ns/1ns

module dif_logic_bench;
  // ========================================================================
  // Stimulus table: stim bits 15..1 are auto, auto start, test, remote, start cfg,
  // op inhibit, remote enable, load inhibit, mains inhibit, gen req, mains req,
  // mains used, mixer, threshold enable, aux disable.
  typedef struct packed {
    logic [15:0] stim;
    logic [5:0] want;
  } dif_row_s;
  dif_row_s rows [11] = '{'{16'hc004, 6'h23}, '{16'hc40c, 6'h07}, '{16'ha402, 6'h20},
    '{16'h1e00, 6'h21}, '{16'h1800, 6'h01}, '{16'h1000, 6'h21}, '{16'h8150, 6'h09},
    '{16'h0170, 6'h19}, '{16'h80e0, 6'h11}, '{16'h8190, 6'h01}, '{16'h00a0, 6'h09}};
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata, rd;
  logic o_avs_waitrequest, o_irq, start, gen_cl, mains_cl, der_act, mix_man, thr_en, aux_en;
  logic mb_acc, mb_rej;
  logic [1:0] der_sel;
  logic [15:0] der_par, mix_sp, s;
  logic [3:0] ana_trip;
  dif_pkg::dif_field_s lvl = '0;
  dif_pkg::dif_field_s fld;
  dif_pkg::dif_ana_s [3:0] ana = '0;
  logic [7:0] pulse_cmd = 8'h00;
  logic a_mode = 1'b0, a_start = 1'b0, t_start = 1'b0, r_start = 1'b0, eng = 1'b0;
  logic g_req = 1'b0, m_req = 1'b0, m_used = 1'b0, mb_valid = 1'b0;
  logic [15:0] mb_reg = 16'h0000;
  int fails = 0;
  int compares = 0;

  dif_field_model field_u (.i_core_clk(i_core_clk), .i_lvl(lvl), .i_pulse(pulse_cmd),
    .o_field(fld));

  dif_logic dut_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq),
    .i_field(fld), .i_auto_mode(a_mode), .i_auto_start_req(a_start),
    .i_test_start_req(t_start), .i_remote_start_req(r_start), .i_engine_starting(eng),
    .i_gen_brk_close_req(g_req), .i_mains_brk_close_req(m_req), .i_mains_brk_used(m_used),
    .i_ana(ana), .i_mb_wr_valid(mb_valid), .i_mb_wr_reg(mb_reg), .o_start_cmd(start),
    .o_gen_brk_close(gen_cl), .o_mains_brk_close(mains_cl), .o_derate_active(der_act),
    .o_derate_sel(der_sel), .o_derate_param(der_par), .o_mixer_manual(mix_man),
    .o_mixer_sp(mix_sp), .o_load_thr_en(thr_en), .o_aux_prot_en(aux_en),
    .o_ana_trip(ana_trip), .o_mb_wr_accept(mb_acc), .o_mb_wr_reject(mb_rej));

  // ========================================================================
  // Clock at 20 MHz.
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  // Compares one result; a mismatch is reported and counted.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // One Avalon access; the request holds until a rising edge sees waitrequest low,
  // and only the watchdog ends a wait that never completes.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    i_avs_writedata <= d;
    do @(posedge i_core_clk);
    while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_core_clk);
  endtask : bus

  // Reads a register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rchk

  // Covers model, two sync flops and the output register with margin.
  task automatic settle;
    repeat (6) @(posedge i_core_clk);
  endtask : settle

  // One contact closure on counter input k, then a quiet gap.
  task automatic pulse(input int k);
    pulse_cmd[k] <= 1'b1;
    @(posedge i_core_clk);
    pulse_cmd <= 8'h00;
    repeat (4) @(posedge i_core_clk);
  endtask : pulse

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Watchdog: the whole sequence needs a few hundred cycles.
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    wrap_up;
  end

  // ========================================================================
  // Main sequence.
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    @(posedge i_core_clk);
    chk({start, gen_cl, mains_cl, der_act, aux_en, o_irq}, 32'h0, "reset outs");
    rchk(8'h24, 32'h0, "mask reset");
    rchk(8'h28, 32'h0, "ctrl reset");
    rchk(8'h30, 32'h0, "derate reset");
    bus(1'b1, 8'h80, 32'hffff_ffff);
    rchk(8'h80, 32'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin
      s = rows[i].stim;
      bus(1'b1, 8'h28, {31'h0, s[11]});
      a_mode <= s[15];
      a_start <= s[14];
      t_start <= s[13];
      r_start <= s[12];
      lvl.op_inhibit <= s[10];
      lvl.rstart_en <= s[9];
      lvl.load_inhibit <= s[8];
      lvl.mains_inhibit <= s[7];
      g_req <= s[6];
      m_req <= s[5];
      m_used <= s[4];
      lvl.mixer_man <= s[3];
      lvl.load_thr_en <= s[2];
      lvl.aux_dis <= s[1];
      settle;
      chk({start, gen_cl, mains_cl, mix_man, thr_en, aux_en}, rows[i].want, "row");
    end
    rchk(8'h20, 32'h200, "start block status");
    $display("test table done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'(8'h30 + 4 * k), {16'h0, 16'(16'h1111 * (k + 1))});
    end
    for (int k = 0; k < 4; k++) begin
      lvl.derate_req <= 4'h1 << k;
      settle;
      chk({der_act, der_sel, der_par}, {1'b1, k[1:0], 16'(16'h1111 * (k + 1))}, "derate");
    end
    lvl.derate_req <= 4'hc;
    settle;
    chk({der_act, der_sel, der_par}, {1'b1, 2'h2, 16'h3333}, "derate pair");
    lvl.derate_req <= 4'h0;
    settle;
    chk(der_act, 1'b0, "derate off");
    $display("test derate done");
    bus(1'b1, 8'h40, 32'h0000_0a0a);
    bus(1'b1, 8'h44, 32'h0000_0b0b);
    for (int g = 1; g >= 0; g--) begin
      lvl.gas_sel <= g[0];
      settle;
      if (g == 0) chk(mix_sp, 16'h0b0b, "gas hold");
      eng <= 1'b1;
      @(posedge i_core_clk);
      eng <= 1'b0;
      settle;
      chk(mix_sp, (g == 1) ? 16'h0b0b : 16'h0a0a, "gas");
    end
    $display("test mixer done");
    bus(1'b0, 8'h20, 32'h0);
    for (int k = 0; k < 8; k++) begin
      repeat (k + 1) pulse(k);
    end
    for (int k = 0; k < 8; k++) begin
      rchk(8'(4 * k), k + 1, "count");
    end
    rchk(8'h20, 32'h0ff, "status");
    rchk(8'h20, 32'h0, "status cleared");
    bus(1'b1, 8'h00, 32'h1234);
    rchk(8'h00, 32'h1, "counter read only");
    lvl.cnt_clr[3] <= 1'b1;
    settle;
    rchk(8'h0c, 32'h0, "clear held");
    pulse(3);
    settle;
    rchk(8'h0c, 32'h0, "clear beats count");
    lvl.cnt_clr[3] <= 1'b0;
    settle;
    pulse(3);
    settle;
    rchk(8'h0c, 32'h1, "count after clear");
    $display("test counters done");
    bus(1'b0, 8'h20, 32'h0);
    bus(1'b1, 8'h24, 32'h1);
    pulse(1);
    settle;
    chk(o_irq, 1'b0, "irq masked");
    pulse(0);
    settle;
    chk(o_irq, 1'b1, "irq raised");
    rchk(8'h20, 32'h3, "irq status");
    chk(o_irq, 1'b0, "irq cleared");
    $display("test irq done");
    for (int se = 0; se < 2; se++) begin
      lvl.serial_en <= se[0];
      settle;
      for (int r = 16'h0064; r < 16'h0068; r++) begin
        mb_valid <= 1'b1;
        mb_reg <= r[15:0];
        @(posedge i_core_clk);
        mb_valid <= 1'b0;
        @(negedge i_core_clk);
        s[0] = (r == 16'h0065 || r == 16'h0066) && se == 0;
        chk({mb_acc, mb_rej}, {~s[0], s[0]}, "modbus");
        @(posedge i_core_clk);
      end
    end
    rchk(8'h20, 32'h100, "reject status");
    $display("test modbus done");
    ana <= {17'h1_0000, 17'h1_2000, 17'h1_0000, 17'h1_2000};
    for (int d = 1; d >= 0; d--) begin
      lvl.ana_dis <= d[0];
      settle;
      chk(ana_trip, (d == 1) ? 4'ha : 4'hf, "analogue");
    end
    $display("test analogue done");
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    @(posedge i_core_clk);
    rchk(8'h04, 32'h0, "count after reset");
    rchk(8'h24, 32'h0, "mask after reset");
    $display("test second reset done");
    wrap_up;
  end
endmodule : dif_logic_bench
